// ==== rtl/dnba_core.v ====
// byte access controller for a 32-byte nonvolatile data memory
// assumes: AXI4-Lite master on clock_i; halt request from same clock
`timescale 1ns/1ps
`default_nettype none
`include "dnba_map.vh"

module dnba_core #(
    parameter integer TICK_CYCLES = `DNBA_TICK_CYCLES,
    parameter integer WRITE_TICKS = `DNBA_WRITE_TICKS,
    parameter integer READ_CYCLES = `DNBA_READ_CYCLES,
    parameter integer DEPTH = 32,
    parameter integer IDX_W = 5
) (
    input wire clock_i,
    input wire rst_i,
    input wire core_halt_i,
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    output reg irq_o
);

    // ---------------------------------------------------------------
    // states and storage
    // ---------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_READ = 2'b01;
    localparam [1:0] ST_WRITE = 2'b10;

    reg [7:0] mem_q [0:DEPTH-1];
    reg [1:0] state_q;
    reg [IDX_W-1:0] index_q;
    reg [7:0] buffer_q;
    reg [7:0] bank_q;
    reg [7:0] pointer_q;
    reg pgm_en_q;
    reg pgm_go_q;
    reg fet_en_q;
    reg fet_go_q;
    reg [1:0] status_q;
    reg [1:0] mask_q;
    reg [31:0] tick_div_q;
    reg [31:0] cnt_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    wire tick = (tick_div_q == TICK_CYCLES - 1);
    wire commit = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;
    wire ar_take = s_axi_arvalid_i & s_axi_arready_o;

    // control register only shows through the window at 040H, bank 1
    function ctrl_reach;
        input [7:0] bank;
        input [7:0] ptr;
        begin
            ctrl_reach = (bank == `DNBA_CTRL_BANK) &&
                (ptr == `DNBA_CTRL_PTR);
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `DNBA_OFS_INDEX) ||
                (addr == `DNBA_OFS_BUFFER) ||
                (addr == `DNBA_OFS_BANK) ||
                (addr == `DNBA_OFS_POINTER) ||
                (addr == `DNBA_OFS_WINDOW) ||
                (addr == `DNBA_OFS_STATUS) ||
                (addr == `DNBA_OFS_MASK);
        end
    endfunction

    wire wr_win = commit && (awaddr_q == `DNBA_OFS_WINDOW) && wstrb_q[0]
        && ctrl_reach(bank_q, pointer_q);
    wire go_fet = wr_win && wdata_q[`DNBA_CTRL_FET_GO] && fet_en_q
        && (state_q == ST_IDLE);
    wire go_pgm = wr_win && wdata_q[`DNBA_CTRL_PGM_GO] && pgm_en_q
        && (state_q == ST_IDLE) && ~go_fet;
    wire wr_done = (state_q == ST_WRITE) && tick
        && (cnt_q == WRITE_TICKS - 1) && ~core_halt_i;

    // ---------------------------------------------------------------
    // write channel: address and data taken in either order
    // ---------------------------------------------------------------
    always @(posedge clock_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `DNBA_RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                awaddr_q <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (commit) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= mapped(awaddr_q) ? `DNBA_RESP_OKAY :
                    `DNBA_RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    always @(posedge clock_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `DNBA_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= mapped(s_axi_araddr_i) ?
                    `DNBA_RESP_OKAY : `DNBA_RESP_SLVERR;
                case (s_axi_araddr_i)
                    `DNBA_OFS_INDEX: begin
                        s_axi_rdata_o <= {27'h000_0000, index_q};
                    end
                    `DNBA_OFS_BUFFER: begin
                        s_axi_rdata_o <= {24'h00_0000, buffer_q};
                    end
                    `DNBA_OFS_BANK: begin
                        s_axi_rdata_o <= {24'h00_0000, bank_q};
                    end
                    `DNBA_OFS_POINTER: begin
                        s_axi_rdata_o <= {24'h00_0000, pointer_q};
                    end
                    `DNBA_OFS_WINDOW: begin
                        // unreachable control reads as zero
                        if (ctrl_reach(bank_q, pointer_q)) begin
                            s_axi_rdata_o <= {28'h000_0000, pgm_en_q,
                                pgm_go_q, fet_en_q, fet_go_q};
                        end else begin
                            s_axi_rdata_o <= 32'h0000_0000;
                        end
                    end
                    `DNBA_OFS_STATUS: begin
                        s_axi_rdata_o <= {30'h0000_0000, status_q};
                    end
                    `DNBA_OFS_MASK: begin
                        s_axi_rdata_o <= {30'h0000_0000, mask_q};
                    end
                    default: begin
                        s_axi_rdata_o <= 32'h0000_0000;
                    end
                endcase
            end
            if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    always @(posedge clock_i) begin
        if (rst_i) begin
            index_q <= `DNBA_RST_INDEX;
            bank_q <= 8'h00;
            pointer_q <= 8'h00;
            pgm_en_q <= 1'b0;
            fet_en_q <= 1'b0;
            mask_q <= 2'b00;
        end else if (commit && wstrb_q[0]) begin
            case (awaddr_q)
                `DNBA_OFS_INDEX: begin
                    index_q <= wdata_q[IDX_W-1:0];
                end
                `DNBA_OFS_BANK: begin
                    bank_q <= wdata_q[7:0];
                end
                `DNBA_OFS_POINTER: begin
                    pointer_q <= wdata_q[7:0];
                end
                `DNBA_OFS_WINDOW: begin
                    if (ctrl_reach(bank_q, pointer_q)) begin
                        pgm_en_q <= wdata_q[`DNBA_CTRL_PGM_EN];
                        fet_en_q <= wdata_q[`DNBA_CTRL_FET_EN];
                    end
                end
                `DNBA_OFS_MASK: begin
                    mask_q <= wdata_q[1:0];
                end
                default: begin
                    mask_q <= mask_q;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // cycle sequencer
    // ---------------------------------------------------------------
    // write time base; free-running, so a write's first tick is partial
    always @(posedge clock_i) begin
        if (rst_i || tick) begin
            tick_div_q <= 32'h0000_0000;
        end else begin
            tick_div_q <= tick_div_q + 32'h0000_0001;
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0000_0000;
            fet_go_q <= 1'b0;
            pgm_go_q <= 1'b0;
            buffer_q <= `DNBA_RST_BYTE;
        end else begin
            if (commit && wstrb_q[0] && awaddr_q == `DNBA_OFS_BUFFER) begin
                buffer_q <= wdata_q[7:0];
            end
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 32'h0000_0000;
                    if (go_fet) begin
                        fet_go_q <= 1'b1;
                        state_q <= ST_READ;
                    end else if (go_pgm) begin
                        pgm_go_q <= 1'b1;
                        state_q <= ST_WRITE;
                    end
                end
                ST_READ: begin
                    if (core_halt_i) begin
                        // halted read fails; buffer left as it was
                        fet_go_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (cnt_q == READ_CYCLES - 1) begin
                        buffer_q <= mem_q[index_q];
                        fet_go_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                ST_WRITE: begin
                    if (core_halt_i) begin
                        fet_go_q <= 1'b0;
                        pgm_go_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (wr_done) begin
                        pgm_go_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                default: begin
                    fet_go_q <= 1'b0;
                    pgm_go_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // aborted write never commits; the cell keeps its old byte
    always @(posedge clock_i) begin
        if (wr_done) begin
            mem_q[index_q] <= buffer_q;
        end
    end

    // ---------------------------------------------------------------
    // interrupt flags: set wins over a same-cycle clear
    // ---------------------------------------------------------------
    always @(posedge clock_i) begin
        if (rst_i) begin
            status_q <= 2'b00;
            irq_o <= 1'b0;
        end else begin
            if (commit && wstrb_q[0] && awaddr_q == `DNBA_OFS_STATUS) begin
                status_q <= (status_q & ~wdata_q[1:0]) |
                    {wr_done, wr_done};
            end else begin
                status_q <= status_q | {wr_done, wr_done};
            end
            irq_o <= |(status_q & mask_q);
        end
    end

endmodule
`default_nettype wire

// ==== rtl/dnba_map.vh ====
// constants of the byte-wide nonvolatile data memory controller
// assumes: included by rtl/dnba_core.v and by the checker and bench, bare include name
`ifndef DNBA_MAP_VH
`define DNBA_MAP_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define DNBA_OFS_INDEX 8'h00
`define DNBA_OFS_BUFFER 8'h04
`define DNBA_OFS_BANK 8'h08
`define DNBA_OFS_POINTER 8'h0C
`define DNBA_OFS_WINDOW 8'h10
`define DNBA_OFS_STATUS 8'h14
`define DNBA_OFS_MASK 8'h18

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define DNBA_CTRL_PGM_EN 3
`define DNBA_CTRL_PGM_GO 2
`define DNBA_CTRL_FET_EN 1
`define DNBA_CTRL_FET_GO 0
`define DNBA_CTRL_PTR 8'h40
`define DNBA_CTRL_BANK 8'h01
`define DNBA_STAT_DONE 0
`define DNBA_STAT_MULTI 1
`define DNBA_RST_BYTE 8'h00
`define DNBA_RST_INDEX 5'h00
`define DNBA_RESP_OKAY 2'b00
`define DNBA_RESP_SLVERR 2'b10

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DNBA_CLK_PERIOD_NS 4
`define DNBA_TICK_NS 1000
`define DNBA_TICK_CYCLES (`DNBA_TICK_NS / `DNBA_CLK_PERIOD_NS)
`define DNBA_WRITE_TICKS 2000
`define DNBA_READ_CYCLES 2

`endif

// ==== test/dnba_props.sv ====
// checker: handshake and field properties at the block's bus ports
// assumes: bound into dnba_core; one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "dnba_map.vh"

module dnba_props (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_wr;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_rd;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence

    a_read_answer: assert property (s_rd |=> s_axi_rvalid_o
        && !s_axi_arready_o) else $error("read answer late");
    a_read_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
        !s_axi_rvalid_o && s_axi_arready_o) else $error("read not released");
    a_write_answer: assert property (s_wr |=> !s_axi_bvalid_o ##1
        s_axi_bvalid_o) else $error("write answer timing");
    a_write_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
        !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
        else $error("write not released");
    a_write_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o
        && !s_axi_wready_o) else $error("write taken while answering");
    a_bad_write: assert property (s_wr ##0 (s_axi_awaddr_i > 8'h18) |->
        ##2 s_axi_bresp_o == `DNBA_RESP_SLVERR) else $error("bad write ok");
    a_bad_read: assert property (s_rd ##0 (s_axi_araddr_i > 8'h18) |=>
        s_axi_rresp_o == `DNBA_RESP_SLVERR && s_axi_rdata_o == 32'h0)
        else $error("bad read ok");
    a_ctrl_width: assert property (
        s_rd ##0 (s_axi_araddr_i == `DNBA_OFS_WINDOW) |=>
        s_axi_rdata_o[31:4] == 28'h0) else $error("control upper bits");
    a_byte_width: assert property (
        s_rd ##0 (s_axi_araddr_i == `DNBA_OFS_BUFFER) |=>
        s_axi_rdata_o[31:8] == 24'h0) else $error("buffer upper bits");
    a_index_width: assert property (
        s_rd ##0 (s_axi_araddr_i == `DNBA_OFS_INDEX) |=>
        s_axi_rdata_o[31:5] == 27'h0) else $error("index upper bits");
    a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o
        && !s_axi_bvalid_o && !s_axi_rvalid_o) else $error("reset state");
endmodule

bind dnba_core dnba_props u_props (.clock_i, .rst_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .irq_o);
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the nvm byte access block
// assumes: dnba_core with a short write timer; bench is the bus master
`timescale 1ns/1ps
`default_nettype none
`include "dnba_map.vh"

module testbench;
    localparam int TK = 4;
    localparam int WT = 3;
    localparam logic [7:0] IDX = `DNBA_OFS_INDEX;
    localparam logic [7:0] BUF = `DNBA_OFS_BUFFER;
    localparam logic [7:0] WIN = `DNBA_OFS_WINDOW;
    localparam logic [7:0] STA = `DNBA_OFS_STATUS;
    localparam logic [7:0] MSK = `DNBA_OFS_MASK;
    logic clock_i = 0, rst_i = 1, core_halt_i = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rv;
    logic awvalid = 0, wvalid = 0, arvalid = 0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rs;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;

    // bready and rready held high: answers are taken at once
    dnba_core #(.TICK_CYCLES(TK), .WRITE_TICKS(WT)) DUT (
        .clock_i(clock_i), .rst_i(rst_i), .core_halt_i(core_halt_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(1'b1), .irq_o(irq));

    always #2 clock_i = ~clock_i;
    // non-blocking so tasks always see the count before the edge
    always @(posedge clock_i) cyc <= cyc + 1;

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // waits for the answer however long; only the watchdog ends a hang
    task automatic wr(logic [7:0] a, logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
    endtask

    task automatic rd(logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        rs = rresp;
    endtask

    task automatic rc(string nm, logic [7:0] a, logic [31:0] e);
        rd(a);
        chk(nm, e, rv);
    endtask

    task automatic poll(int b);
        do begin
            rd(WIN);
        end while (rv[b] !== 1'b0);
    endtask

    task automatic t_reset();
        rc("index", IDX, 0);
        rc("buffer", BUF, 0);
        rc("status", STA, 0);
        rc("mask", MSK, 0);
        chk("irq", 0, irq);
        wr(8'h1c, 32'h0000_00ff);
        chk("bresp", `DNBA_RESP_SLVERR, rs);
        rd(8'h1c);
        chk("rresp", `DNBA_RESP_SLVERR, rs);
        wstrb <= 4'h0;
        wr(IDX, 32'h0000_0007);
        wstrb <= 4'hf;
        chk("strb_resp", `DNBA_RESP_OKAY, rs);
        rc("strb_off", IDX, 0);
        $display("test reset and map done");
    endtask

    task automatic t_guard();
        wr(`DNBA_OFS_POINTER, `DNBA_CTRL_PTR);
        wr(WIN, 32'h0000_000a);
        rc("win_bank0", WIN, 0);
        wr(`DNBA_OFS_BANK, `DNBA_CTRL_BANK);
        rc("win_bank1", WIN, 0);
        wr(WIN, 32'h0000_0005);
        rc("go_no_en", WIN, 0);
        wr(WIN, 32'h0000_000f);
        rc("go_same_write", WIN, 32'h0000_000a);
        rc("no_status", STA, 0);
        $display("test guard done");
    endtask

    task automatic t_rw(logic [4:0] i, logic [7:0] d);
        int t0;
        wr(IDX, {27'h0, i});
        wr(BUF, {24'h0, d});
        // enable then go back to back, nothing in between
        wr(WIN, 32'h0000_000a);
        wr(WIN, 32'h0000_000e);
        t0 = cyc;
        rc("pgm_go_held", WIN, 32'h0000_000e);
        poll(2);
        chk("pgm_go_clr", 32'h0000_000a, rv);
        chk("write_len", 1, (cyc - t0) >= (WT - 1) * TK);
        chk("write_max", 1, (cyc - t0) <= WT * TK + 3);
        rc("done_set", STA, 32'h0000_0003);
        wr(BUF, 0);
        wr(WIN, 32'h0000_000b);
        poll(0);
        chk("fet_go_clr", 32'h0000_000a, rv);
        rc("fetched", BUF, {24'h0, d});
        rc("kept", BUF, {24'h0, d});
        $display("test write and read done");
    endtask

    task automatic t_irq();
        wr(MSK, 32'h0000_0001);
        repeat (2) @(posedge clock_i);
        chk("irq_on", 1, irq);
        wr(MSK, 0);
        repeat (2) @(posedge clock_i);
        chk("irq_masked", 0, irq);
        wr(STA, 32'h0000_0001);
        rc("done_clr", STA, 32'h0000_0002);
        wr(MSK, 32'h0000_0002);
        repeat (2) @(posedge clock_i);
        chk("irq_multi", 1, irq);
        wr(STA, 32'h0000_0002);
        repeat (2) @(posedge clock_i);
        chk("irq_off", 0, irq);
        rc("all_clr", STA, 0);
        $display("test interrupt done");
    endtask

    task automatic t_halt();
        wr(IDX, 32'h0000_0005);
        wr(BUF, 32'h0000_0077);
        wr(WIN, 32'h0000_000e);
        core_halt_i <= 1'b1;
        @(posedge clock_i);
        core_halt_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rc("halt_go_clr", WIN, 32'h0000_000a);
        rc("halt_no_done", STA, 0);
        rc("halt_buf", BUF, 32'h0000_0077);
        wr(WIN, 32'h0000_000b);
        core_halt_i <= 1'b1;
        @(posedge clock_i);
        core_halt_i <= 1'b0;
        rc("halt_rd_go", WIN, 32'h0000_000a);
        rc("halt_rd_buf", BUF, 32'h0000_0077);
        wr(WIN, 32'h0000_000b);
        poll(0);
        rc("halt_old_cell", BUF, 32'h0000_00a5);
        wr(WIN, 32'h0000_0000);
        wr(`DNBA_OFS_BANK, 32'h0000_0000);
        wr(WIN, 32'h0000_000f);
        wr(`DNBA_OFS_BANK, `DNBA_CTRL_BANK);
        rc("idle_locked", WIN, 0);
        wr(`DNBA_OFS_BANK, 32'h0000_0000);
        $display("test halt done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // bound is generous: the whole run is a few hundred cycles
    initial begin
        #40000;
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_guard();
        t_rw(5'h05, 8'ha5);
        t_irq();
        t_rw(5'h1f, 8'h3c);
        wr(STA, 32'h0000_0003);
        t_halt();
        test_done();
    end
endmodule
`default_nettype wire
